// [hdl/tdc_regs.svh]
// Purpose: Offsets, field positions, codes and times of the tape control block
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef TDC_REGS_SVH
`define TDC_REGS_SVH
// ============================================================
// Clock and times
`define TDC_CLK_HZ 100000000
`define TDC_POWERUP_S 3
// ============================================================
// Register byte addresses, control bits and response codes
`define TDC_ADDR_W 8
`define TDC_REG_CTRL 8'h00
`define TDC_REG_STATE 8'h04
`define TDC_REG_STAT01 8'h08
`define TDC_REG_COUNT 8'h0C
`define TDC_CTRL_LAMP_TEST 0
`define TDC_CTRL_INIT 1
`define TDC_RESP_OKAY 2'h0
`define TDC_RESP_SLVERR 2'h2
// ============================================================
// Command byte layout
`define TDC_GRP_HI 7
`define TDC_GRP_LO 5
`define TDC_GRP_SELECT 3'h0
`define TDC_GRP_POSITION 3'h1
`define TDC_GRP_WRITE 3'h2
`define TDC_GRP_READ 3'h3
`define TDC_GRP_STATUS 3'h4
`define TDC_SEL_LIGHT_BIT 4
`define TDC_DRIVE0 4'h1
`define TDC_POS_QUAL 2'h0
// ============================================================
// Status transfer
`define TDC_STAT_FIRST 3'h0
`define TDC_STAT_LAST 3'h5
`define TDC_CNT_INC 16'h0001
`define TDC_CNT_ZERO 16'h0000
`endif

// [hdl/tdc_pkg.sv]
// Purpose: Types of the tape control block
// Assumes: Nothing
// Notes: Constants live in tdc_regs.svh
package tdc_pkg;
    typedef enum {ST_INIT, ST_HRST, ST_IDLE, ST_TAKE, ST_ACK, ST_VALID, ST_BUSY,
        ST_SBYTE, ST_SWAIT} tdc_state_t;
    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b0;
    } tdc_stat_t;
    typedef struct packed {
        logic req_n;
        logic online_n;
        logic reset_n;
        logic [7:0] data;
    } tdc_hostin_t;
endpackage

// [hdl/tdc_ctrl.sv]
// Purpose: Drive-side control and status logic of a cartridge tape drive
// Assumes: Host lines are asynchronous; drive sensors and engine on I_CLK_SYS
// Notes: Registers over AXI4-Lite; tape motion lives in the engine outside
`timescale 1ns/1ps
`include "tdc_regs.svh"
module tdc_ctrl import tdc_pkg::*; #(
    parameter int INIT_CYCLES = `TDC_POWERUP_S * `TDC_CLK_HZ
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic [7:0] I_BUS_DATA,
    output logic [7:0] O_BUS_DATA,
    output logic O_BUS_OE_N,
    input wire logic I_REQUEST_N,
    input wire logic I_ONLINE_N,
    input wire logic I_HOST_RESET_N,
    output logic O_READY_N,
    output logic O_EXCEPTION_N,
    output logic O_DIRECTION_N,
    input wire logic I_CART_PRESENT,
    input wire logic I_AT_BOT,
    input wire logic I_MIDTAPE_STOP,
    input wire logic I_SEQ_DONE,
    input wire logic I_SEQ_END_BOT,
    input wire logic I_WRITE_PROTECT,
    input wire logic I_DRIVE_ONLINE,
    input wire logic I_WRITE_ACTIVE,
    input wire logic I_READ_ACTIVE,
    input wire logic [3:0] I_ENG_STAT0,
    input wire logic [1:0] I_ENG_STAT1,
    input wire logic [1:0] I_COUNT_INC,
    output logic O_CMD_START,
    output logic [7:0] O_CMD_CODE,
    output logic O_RECAL,
    output logic O_SELECT_LAMP,
    output logic [3:0] O_DRIVE_SEL,
    output logic O_MIDTAPE_STOP_FLAG,
    input wire logic [7:0] I_AXI_AWADDR,
    input wire logic I_AXI_AWVALID,
    output logic O_AXI_AWREADY,
    input wire logic [31:0] I_AXI_WDATA,
    input wire logic [3:0] I_AXI_WSTRB,
    input wire logic I_AXI_WVALID,
    output logic O_AXI_WREADY,
    output logic [1:0] O_AXI_BRESP,
    output logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic [7:0] I_AXI_ARADDR,
    input wire logic I_AXI_ARVALID,
    output logic O_AXI_ARREADY,
    output logic [31:0] O_AXI_RDATA,
    output logic [1:0] O_AXI_RRESP,
    output logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY
);
    // ============================================================
    // Host line synchronisers
    tdc_hostin_t host_meta;
    tdc_hostin_t host_s;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            host_meta <= '1;
            host_s <= '1;
        end else begin
            host_meta <= {I_REQUEST_N, I_ONLINE_N, I_HOST_RESET_N, I_BUS_DATA};
            host_s <= host_meta;
        end
    end
    wire req = !host_s.req_n;
    // ============================================================
    // State and working registers
    tdc_state_t state;
    logic [31:0] init_cnt;
    logic [7:0] cmd;
    logic [2:0] idx;
    logic midtape_stop_flag;
    logic light;
    logic selected;
    logic [3:0] drive_addr;
    logic exc;
    logic dir_n;
    logic stat_illegal;
    logic reset_occ;
    logic cart_missing;
    logic cart_prev;
    logic lamp_test;
    logic init_req;
    logic [15:0] err_cnt [0:1];
    tdc_stat_t stat;
    logic illegal;
    logic [7:0] next_byte;
    wire [2:0] grp = cmd[`TDC_GRP_HI:`TDC_GRP_LO];
    wire init_done = (state == ST_INIT) && (init_cnt == 32'h0);
    wire in_valid = (state == ST_VALID);
    wire stat_end = (state == ST_SWAIT) && !req && (idx == `TDC_STAT_LAST);
    wire sel_ok = in_valid && !illegal && (grp == `TDC_GRP_SELECT);
    wire cart_pulled = cart_prev && !I_CART_PRESENT;
    // ============================================================
    // Command validation
    always_comb begin
        illegal = 1'b0;
        case (grp)
            `TDC_GRP_SELECT: illegal = !$onehot(cmd[3:0])
                || (midtape_stop_flag && (cmd[3:0] != drive_addr));
            `TDC_GRP_POSITION: illegal = !$onehot(cmd[2:0]) || (cmd[4:3] != `TDC_POS_QUAL);
            `TDC_GRP_WRITE: illegal = host_s.online_n || I_WRITE_PROTECT;
            `TDC_GRP_READ: illegal = host_s.online_n;
            `TDC_GRP_STATUS: illegal = 1'b0;
            default: illegal = 1'b1;
        endcase
        if ((I_WRITE_ACTIVE && grp != `TDC_GRP_WRITE) || (I_READ_ACTIVE && grp != `TDC_GRP_READ)) begin
            illegal = 1'b1;
        end
    end
    // ============================================================
    // Main sequencer
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            state <= ST_INIT;
            init_cnt <= INIT_CYCLES - 1;
            cmd <= 8'h00;
            idx <= `TDC_STAT_FIRST;
        end else if (!host_s.reset_n) begin
            state <= ST_HRST;
            init_cnt <= 32'h0;
        end else begin
            case (state)
                ST_HRST: state <= ST_INIT;
                ST_INIT: begin
                    if (init_cnt == 32'h0) begin
                        state <= ST_IDLE;
                    end else begin
                        init_cnt <= init_cnt - 32'h1;
                    end
                    if (init_req) begin
                        init_cnt <= 32'h0;
                    end
                end
                ST_IDLE: begin
                    if (init_req) begin
                        state <= ST_INIT;
                        init_cnt <= 32'h0;
                    end else if (req) begin
                        cmd <= host_s.data;
                        state <= ST_TAKE;
                    end
                end
                ST_TAKE: state <= ST_ACK;
                ST_ACK: if (!req) state <= ST_VALID;
                ST_VALID: begin
                    if (illegal || grp == `TDC_GRP_SELECT) begin
                        state <= ST_IDLE;
                    end else if (grp == `TDC_GRP_STATUS) begin
                        state <= ST_SBYTE;
                        idx <= `TDC_STAT_FIRST;
                    end else begin
                        state <= ST_BUSY;
                    end
                end
                ST_BUSY: if (I_SEQ_DONE) state <= ST_IDLE;
                ST_SBYTE: if (req) state <= ST_SWAIT;
                ST_SWAIT: begin
                    if (!req) begin
                        if (idx == `TDC_STAT_LAST) begin
                            state <= ST_IDLE;
                        end else begin
                            idx <= idx + 3'h1;
                            state <= ST_SBYTE;
                        end
                    end
                end
                default: state <= ST_INIT;
            endcase
        end
    end
    // Ready is true while waiting for a command, acknowledging one, or offering a byte
    assign O_READY_N = !((state == ST_IDLE) || (state == ST_ACK) || (state == ST_SBYTE));
    // ============================================================
    // Engine command and recalibration pulses
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_CMD_START <= 1'b0;
            O_CMD_CODE <= 8'h00;
            O_RECAL <= 1'b0;
        end else begin
            O_CMD_START <= in_valid && !illegal && (grp != `TDC_GRP_SELECT) && (grp != `TDC_GRP_STATUS);
            if (in_valid) begin
                O_CMD_CODE <= cmd;
            end
            O_RECAL <= init_done;
        end
    end
    // ============================================================
    // Midtape stop flag
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            midtape_stop_flag <= 1'b0;
        end else if (I_AT_BOT || init_done) begin
            midtape_stop_flag <= 1'b0;
        end else if (I_MIDTAPE_STOP) begin
            midtape_stop_flag <= 1'b1;
        end
    end
    assign O_MIDTAPE_STOP_FLAG = midtape_stop_flag;
    // ============================================================
    // Drive selection and lamp
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            light <= 1'b0;
            selected <= 1'b0;
            drive_addr <= `TDC_DRIVE0;
        end else if (state == ST_HRST) begin
            selected <= 1'b0;
        end else if (init_done) begin
            light <= 1'b0;
            selected <= 1'b1;
            drive_addr <= `TDC_DRIVE0;
        end else if (sel_ok) begin
            light <= cmd[`TDC_SEL_LIGHT_BIT];
            drive_addr <= cmd[3:0];
            selected <= 1'b1;
        end else if (I_SEQ_END_BOT && !light) begin
            selected <= 1'b0;
        end
    end
    assign O_SELECT_LAMP = selected || lamp_test;
    assign O_DRIVE_SEL = selected ? drive_addr : 4'h0;
    // ============================================================
    // Exception, sticky status bits and direction
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            exc <= 1'b0;
            stat_illegal <= 1'b0;
            reset_occ <= 1'b0;
            cart_missing <= 1'b0;
            cart_prev <= 1'b0;
            dir_n <= 1'b1;
        end else begin
            cart_prev <= I_CART_PRESENT;
            if (init_done || (in_valid && illegal) || (cart_pulled && O_SELECT_LAMP && dir_n)) begin
                exc <= 1'b1;
            end else if (state == ST_IDLE && req) begin
                exc <= 1'b0;
            end
            if (in_valid && illegal) begin
                stat_illegal <= 1'b1;
            end else if (stat_end) begin
                stat_illegal <= 1'b0;
            end
            if (init_done) begin
                reset_occ <= 1'b1;
            end else if (stat_end) begin
                reset_occ <= 1'b0;
            end
            if (cart_pulled && O_SELECT_LAMP && dir_n) begin
                cart_missing <= 1'b1;
            end else if (stat_end) begin
                cart_missing <= 1'b0;
            end
            if (in_valid && !illegal && grp == `TDC_GRP_STATUS) begin
                dir_n <= 1'b0;
            end else if (stat_end) begin
                dir_n <= 1'b1;
            end
        end
    end
    assign O_EXCEPTION_N = !exc;
    assign O_DIRECTION_N = dir_n;
    assign O_BUS_OE_N = dir_n;
    // ============================================================
    // Error counters cleared by a status read
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cnt
            always_ff @(posedge I_CLK_SYS) begin
                if (I_RESET) begin
                    err_cnt[g] <= `TDC_CNT_ZERO;
                end else if (stat_end) begin
                    err_cnt[g] <= I_COUNT_INC[g] ? `TDC_CNT_INC : `TDC_CNT_ZERO;
                end else if (I_COUNT_INC[g]) begin
                    err_cnt[g] <= err_cnt[g] + `TDC_CNT_INC;
                end
            end
        end
    endgenerate
    // ============================================================
    // Status bytes and bus data
    always_comb begin
        stat.b0 = {1'b0, cart_missing || !I_CART_PRESENT, !I_DRIVE_ONLINE, I_WRITE_PROTECT, I_ENG_STAT0};
        stat.b0[7] = |stat.b0[6:0];
        stat.b1 = {1'b0, stat_illegal, I_ENG_STAT1, I_AT_BOT, 2'h0, reset_occ};
        stat.b1[7] = |stat.b1[6:0];
        case (idx)
            3'h0: next_byte = stat.b0;
            3'h1: next_byte = stat.b1;
            3'h2: next_byte = err_cnt[0][15:8];
            3'h3: next_byte = err_cnt[0][7:0];
            3'h4: next_byte = err_cnt[1][15:8];
            default: next_byte = err_cnt[1][7:0];
        endcase
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_BUS_DATA <= 8'h00;
        end else begin
            O_BUS_DATA <= next_byte;
        end
    end
    // ============================================================
    // AXI4-Lite register slave
    logic [31:0] rd_word;
    logic rd_hit;
    assign O_AXI_AWREADY = I_AXI_AWVALID && I_AXI_WVALID && !O_AXI_BVALID;
    assign O_AXI_WREADY = O_AXI_AWREADY;
    assign O_AXI_ARREADY = !O_AXI_RVALID;
    wire wr_go = O_AXI_AWREADY;
    wire wr_ctrl = wr_go && (I_AXI_AWADDR == `TDC_REG_CTRL) && I_AXI_WSTRB[0];
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_AXI_BVALID <= 1'b0;
            O_AXI_BRESP <= `TDC_RESP_OKAY;
            lamp_test <= 1'b0;
            init_req <= 1'b0;
        end else begin
            init_req <= wr_ctrl && I_AXI_WDATA[`TDC_CTRL_INIT];
            if (wr_ctrl) begin
                lamp_test <= I_AXI_WDATA[`TDC_CTRL_LAMP_TEST];
            end
            if (wr_go) begin
                O_AXI_BVALID <= 1'b1;
                O_AXI_BRESP <= (I_AXI_AWADDR == `TDC_REG_CTRL) ? `TDC_RESP_OKAY : `TDC_RESP_SLVERR;
            end else if (I_AXI_BREADY) begin
                O_AXI_BVALID <= 1'b0;
            end
        end
    end
    always_comb begin
        rd_hit = 1'b1;
        case (I_AXI_ARADDR)
            `TDC_REG_CTRL: rd_word = {30'h0, 1'b0, lamp_test};
            `TDC_REG_STATE: rd_word = {22'h0, !dir_n, exc, drive_addr, 1'b0, selected, light, midtape_stop_flag};
            `TDC_REG_STAT01: rd_word = {16'h0, stat};
            `TDC_REG_COUNT: rd_word = {err_cnt[0], err_cnt[1]};
            default: begin
                rd_word = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_AXI_RVALID <= 1'b0;
            O_AXI_RDATA <= 32'h0;
            O_AXI_RRESP <= `TDC_RESP_OKAY;
        end else if (I_AXI_ARVALID && O_AXI_ARREADY) begin
            O_AXI_RVALID <= 1'b1;
            O_AXI_RDATA <= rd_word;
            O_AXI_RRESP <= rd_hit ? `TDC_RESP_OKAY : `TDC_RESP_SLVERR;
        end else if (I_AXI_RREADY) begin
            O_AXI_RVALID <= 1'b0;
        end
    end
    // ============================================================
    // Assertions
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);
    sequence s_cmd_taken;
        (state == ST_IDLE) && req && host_s.reset_n && !init_req;
    endsequence
    sequence s_status_ok;
        in_valid && !illegal && (grp == `TDC_GRP_STATUS) && host_s.reset_n;
    endsequence
    a_flag_set_mid: assert property (I_MIDTAPE_STOP && !I_AT_BOT && !init_done |=> midtape_stop_flag)
        else $error("midtape flag not set");
    a_flag_bot_zero: assert property (I_AT_BOT |=> !midtape_stop_flag)
        else $error("midtape flag set at tape start");
    a_light_hold: assert property ($fell(selected) |-> $past(!light) || $past(state) == ST_HRST)
        else $error("lit drive deselected");
    a_bot_deselect: assert property (I_SEQ_END_BOT && !light && selected && !sel_ok && !init_done
        && host_s.reset_n |=> !selected)
        else $error("no deselect at tape start");
    a_init_done: assert property (init_done && host_s.reset_n |=> !O_EXCEPTION_N && !light
        && O_DRIVE_SEL == `TDC_DRIVE0 && O_RECAL)
        else $error("initialisation result wrong");
    a_take_ack: assert property (s_cmd_taken |=> O_READY_N ##1 !O_READY_N && O_EXCEPTION_N)
        else $error("command handshake wrong");
    a_illegal_cmd: assert property (in_valid && illegal && host_s.reset_n |=> stat_illegal && !O_EXCEPTION_N
        && state == ST_IDLE)
        else $error("illegal command not flagged");
    a_extract_flag: assert property (cart_pulled && O_SELECT_LAMP && dir_n |=> cart_missing && !O_EXCEPTION_N)
        else $error("extraction not reported");
    a_dir_turn: assert property (s_status_ok |=> !O_DIRECTION_N && !O_BUS_OE_N && !O_READY_N)
        else $error("direction not turned");
    a_six_bytes: assert property ($rose(O_DIRECTION_N) |-> $past(idx) == `TDC_STAT_LAST)
        else $error("status ended early");
endmodule

// [test/tdc_host.sv]
// Purpose: Host tape controller model on the command bus
// Assumes: Device answers on the active low handshake lines
// Notes: Bus shows the inverse of the last byte once released
`timescale 1ns/1ps
module tdc_host #(
    parameter int HOLD = 2000
) (
    input wire logic clk,
    input wire logic ready_n,
    input wire logic [7:0] dev_data,
    output logic req_n,
    output logic reset_n,
    output logic online_n,
    output logic [7:0] data,
    output logic got,
    output logic [7:0] got_byte
);
    initial begin
        req_n = 1'b1;
        reset_n = 1'b1;
        online_n = 1'b0;
        data = 8'h00;
        got = 1'b0;
        got_byte = 8'h00;
    end
    task automatic wait_rdy(input logic v);
        do @(posedge clk); while (ready_n !== v);
    endtask
    // ============================================================
    // Command and status transfers
    task automatic cmd(input logic [7:0] b);
        wait_rdy(1'b0);
        data <= b;
        req_n <= 1'b0;
        wait_rdy(1'b1);
        wait_rdy(1'b0);
        req_n <= 1'b1;
        data <= ~b;
        wait_rdy(1'b1);
        @(posedge clk);
    endtask
    task automatic status();
        cmd(8'h80);
        for (int i = 0; i < 6; i++) begin
            wait_rdy(1'b0);
            @(posedge clk);
            got_byte <= dev_data;
            got <= 1'b1;
            req_n <= 1'b0;
            @(posedge clk);
            got <= 1'b0;
            repeat (HOLD) @(posedge clk);
            wait_rdy(1'b1);
            req_n <= 1'b1;
        end
        wait_rdy(1'b0);
    endtask
    task automatic hreset();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (1300) @(posedge clk);
        reset_n <= 1'b1;
    endtask
endmodule

// [test/tb_tdc_ctrl.sv]
// Purpose: Self-checking bench of the tape control block
// Assumes: Shortened power-up count of 20 cycles
// Notes: Expected values queued, compared by a monitor
`timescale 1ns/1ps
`include "tdc_regs.svh"
module tb_tdc_ctrl;
    logic clk = 0, rst = 1, cart = 1, bot = 1, mid = 0, send = 0;
    logic [3:0] s0, sel, n, m, nrecal = 0;
    logic oe_n, cst, recal, wp = 0, wact = 0, ract = 0, sdone = 0, dol = 1;
    logic [7:0] ccode;
    logic [1:0] s1, inc = 0, bresp, rresp;
    logic [7:0] hdata, ddata, gb, awaddr = 0, araddr = 0;
    logic req_n, on_n, hr_n, rdy_n, exc_n, dir_n, got, lamp, flag, awr, wr, bv, arr, rv;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [31:0] wdata = 0, rdata;
    logic [15:0] rnd = 16'hED2E;
    int fails = 0, check_count = 0;
    logic [7:0] qs[$], qc[$];
    logic [33:0] qr[$];
    tdc_ctrl #(.INIT_CYCLES(20)) i_tdc_ctrl (.I_CLK_SYS(clk), .I_RESET(rst), .I_BUS_DATA(hdata),
        .O_BUS_DATA(ddata), .O_BUS_OE_N(oe_n), .I_REQUEST_N(req_n), .I_ONLINE_N(on_n), .I_HOST_RESET_N(hr_n),
        .O_READY_N(rdy_n), .O_EXCEPTION_N(exc_n), .O_DIRECTION_N(dir_n), .I_CART_PRESENT(cart),
        .I_AT_BOT(bot), .I_MIDTAPE_STOP(mid), .I_SEQ_DONE(sdone), .I_SEQ_END_BOT(send),
        .I_WRITE_PROTECT(wp), .I_DRIVE_ONLINE(dol), .I_WRITE_ACTIVE(wact), .I_READ_ACTIVE(ract),
        .I_ENG_STAT0(s0), .I_ENG_STAT1(s1), .I_COUNT_INC(inc), .O_CMD_START(cst), .O_CMD_CODE(ccode),
        .O_RECAL(recal), .O_SELECT_LAMP(lamp), .O_DRIVE_SEL(sel), .O_MIDTAPE_STOP_FLAG(flag),
        .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_WDATA(wdata),
        .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wv), .O_AXI_WREADY(wr), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bv),
        .I_AXI_BREADY(bre), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
        .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rv), .I_AXI_RREADY(rre));
    tdc_host i_tdc_host (.clk(clk), .ready_n(rdy_n), .dev_data(ddata), .req_n(req_n), .reset_n(hr_n),
        .online_n(on_n), .data(hdata), .got(got), .got_byte(gb));
    initial forever #5 clk = ~clk;
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
    // ============================================================
    // Compare and helper tasks
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic miss(input string nm, input logic [33:0] e, input logic [33:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        miss(nm, 34'(e), 34'(g));
    endtask
    task automatic cmp_flag(input string nm, input logic [3:0] e, input logic [3:0] g);
        miss(nm, 34'(e), 34'(g));
    endtask
    task automatic cmp_word(input string nm, input logic [33:0] e, input logic [33:0] g);
        miss(nm, e, g);
    endtask
    task automatic chk_exc();
        for (int i = 0; i < 100 && exc_n !== 1'b0; i++) @(posedge clk);
        cmp_flag("exception", 4'h0, {3'h0, exc_n});
    endtask
    task automatic exp_stat(input logic ill, input logic rs, input logic [3:0] sc, input logic [3:0] uc);
        qs.push_back({|s0, 3'b000, s0});
        qs.push_back({1'b1, ill, s1, 1'b1, 2'b00, rs});
        qs.push_back(8'h00);
        qs.push_back({4'h0, sc});
        qs.push_back(8'h00);
        qs.push_back({4'h0, uc});
    endtask
    task automatic end_bot();
        @(posedge clk) send <= 1'b1;
        @(posedge clk) send <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk) {awaddr, wdata, awv, wv, bre} <= {a, d, 3'b111};
        do @(posedge clk); while (!(awr === 1'b1 && wr === 1'b1));
        {awv, wv} <= 2'b00;
        do @(posedge clk); while (bv !== 1'b1);
        cmp_flag("bresp", {2'b00, r}, {2'b00, bresp});
        bre <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        qr.push_back(e);
        @(posedge clk) {araddr, arv, rre} <= {a, 2'b11};
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rre <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (got === 1'b1) cmp_byte("status byte", qs.pop_front(), gb);
        if (rv === 1'b1 && rre === 1'b1) cmp_word("read data", qr.pop_front(), {rresp, rdata});
        if (got === 1'b1) cmp_flag("bus enable", 4'h0, {3'h0, oe_n});
        if (cst === 1'b1) cmp_byte("command code", qc.pop_front(), ccode);
        if (recal === 1'b1) nrecal++;
    end
    // ============================================================
    // Main sequence
    initial begin
        rnd = lfsr(rnd);
        s0 = rnd[3:0];
        s1 = rnd[5:4];
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk_exc();
        cmp_flag("drive", 4'h1, sel);
        cmp_flag("midflag", 4'h0, {3'h0, flag});
        exp_stat(1'b0, 1'b1, 4'h0, 4'h0);
        i_tdc_host.status();
        cmp_flag("direction", 4'h1, {3'h0, dir_n});
        cmp_flag("exc clear", 4'h1, {3'h0, exc_n});
        $display("test init and status done");
        i_tdc_host.cmd(8'h14);
        cmp_flag("drive", 4'h4, sel);
        cmp_flag("lamp", 4'h1, {3'h0, lamp});
        @(posedge clk) {bot, mid} <= 2'b01;
        @(posedge clk) mid <= 1'b0;
        repeat (3) @(posedge clk);
        cmp_flag("midflag", 4'h1, {3'h0, flag});
        i_tdc_host.cmd(8'h11);
        chk_exc();
        cmp_flag("drive", 4'h4, sel);
        @(posedge clk) bot <= 1'b1;
        repeat (3) @(posedge clk);
        cmp_flag("midflag", 4'h0, {3'h0, flag});
        rnd = lfsr(rnd);
        n = {1'b0, rnd[2:0]} + 4'h1;
        m = {1'b0, rnd[5:3]};
        for (int i = 0; i < 8; i++) @(posedge clk) inc <= {4'(i) < m, 4'(i) < n};
        @(posedge clk) inc <= 2'b00;
        exp_stat(1'b1, 1'b0, n, m);
        i_tdc_host.status();
        $display("test illegal and counts done");
        @(posedge clk) cart <= 1'b0;
        chk_exc();
        @(posedge clk) cart <= 1'b1;
        i_tdc_host.cmd(8'h03);
        cmp_flag("drive", 4'h4, sel);
        i_tdc_host.cmd(8'h01);
        end_bot();
        cmp_flag("drive", 4'h0, sel);
        cmp_flag("lamp", 4'h0, {3'h0, lamp});
        i_tdc_host.cmd(8'h11);
        end_bot();
        cmp_flag("drive", 4'h1, sel);
        $display("test selection done");
        {wp, ract} <= 2'b10;
        i_tdc_host.cmd(8'h40);
        chk_exc();
        {wp, ract} <= 2'b01;
        i_tdc_host.cmd(8'h40);
        chk_exc();
        {ract, wact} <= 2'b01;
        i_tdc_host.cmd(8'h60);
        chk_exc();
        wact <= 1'b0;
        qc.push_back(8'h21);
        i_tdc_host.cmd(8'h21);
        cmp_flag("busy", 4'h1, {3'h0, rdy_n});
        @(posedge clk) sdone <= 1'b1;
        @(posedge clk) sdone <= 1'b0;
        $display("test tape commands done");
        fork
            i_tdc_host.hreset();
            begin
                repeat (100) @(posedge clk);
                cmp_flag("drive", 4'h0, sel);
            end
        join
        chk_exc();
        cmp_flag("drive", 4'h1, sel);
        axi_wr(8'h00, 32'h0000_0001, `TDC_RESP_OKAY);
        axi_rd(8'h00, {`TDC_RESP_OKAY, 32'h0000_0001});
        axi_rd(8'h10, {`TDC_RESP_SLVERR, 32'h0000_0000});
        dol <= 1'b0;
        axi_rd(8'h08, {`TDC_RESP_OKAY, 16'h0, 2'b11, s1, 4'b1001, 4'b1110, s0});
        axi_wr(8'h08, 32'h0000_00FF, `TDC_RESP_SLVERR);
        cmp_flag("recal count", 4'h2, nrecal);
        $display("test reset and registers done");
        tally_and_finish();
    end
endmodule
